// [inc/t16_defines.svh]
// Register offsets, field positions, reset values and counts of the 16-bit timer
`ifndef T16_DEFINES_SVH
`define T16_DEFINES_SVH

// ----------------------------------------
// Register offsets on the 6-bit register bus
// ----------------------------------------
`define T16_OFS_CTRL_A 6'h2f
`define T16_OFS_CTRL_B 6'h2e
`define T16_OFS_CNT_H 6'h2d
`define T16_OFS_CNT_L 6'h2c
`define T16_OFS_CMP_A_H 6'h2b
`define T16_OFS_CMP_A_L 6'h2a
`define T16_OFS_CMP_B_H 6'h29
`define T16_OFS_CMP_B_L 6'h28
`define T16_OFS_CAP_H 6'h27
`define T16_OFS_CAP_L 6'h26

// ----------------------------------------
// Field positions
// ----------------------------------------
`define T16_A_MODE_A_HI 7
`define T16_A_MODE_A_LO 6
`define T16_A_MODE_B_HI 5
`define T16_A_MODE_B_LO 4
`define T16_A_FORCE_A 3
`define T16_A_FORCE_B 2
`define T16_B_FILTER 7
`define T16_B_EDGE 6
`define T16_B_CLEAR 3

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define T16_CTRL_A_RST 8'h00
`define T16_CTRL_B_RST 8'h00
`define T16_CTRL_B_MASK 8'hcf
`define T16_TOP_8 16'h00ff
`define T16_TOP_9 16'h01ff
`define T16_TOP_10 16'h03ff
`define T16_FILTER_SAMPLES 4

`endif

// [inc/t16_pkg.sv]
// Types shared by the 16-bit timer design
package t16_pkg;

  // Output control register layout
  typedef struct packed {
    logic [1:0] mode_a;
    logic [1:0] mode_b;
    logic force_a;
    logic force_b;
    logic [1:0] pwm_res;
  } t16_ctrl_a_s;

  // Input and clock control register layout
  typedef struct packed {
    logic filter_en;
    logic edge_sel;
    logic [1:0] rsvd;
    logic clear_on_match_a;
    logic [2:0] clk_sel;
  } t16_ctrl_b_s;

  // Register bus request
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } t16_bus_s;

  // Counting style
  typedef enum logic [1:0] {
    T16_CNT_NORMAL,
    T16_CNT_UPDOWN,
    T16_CNT_WRAP
  } t16_style_e;

endpackage : t16_pkg

// [src/t16_capture.sv]
// Capture pin noise filter and edge trigger
`timescale 1ns/1ps
`default_nettype none
`include "t16_defines.svh"

module t16_capture
  import t16_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pin,
  input wire logic filter_en,
  input wire logic edge_sel,
  output logic trig
);

  logic [`T16_FILTER_SAMPLES-1:0] hist_q, hist_d;
  logic level_q, level_d;
  logic trig_d;

  // Sample history, filtered level and edge check
  always_comb begin
    hist_d = {hist_q[`T16_FILTER_SAMPLES-2:0], pin};
    level_d = level_q;
    if (!filter_en) begin
      level_d = pin;
    end else if (&hist_d) begin
      level_d = 1'b1;
    end else if (~|hist_d) begin
      level_d = 1'b0;
    end
    // Rising when edge select set, falling when clear
    trig_d = (level_d != level_q) && (level_d == edge_sel);
  end

  // State registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hist_q <= '0;
      level_q <= 1'b0;
      trig <= 1'b0;
    end else begin
      hist_q <= hist_d;
      level_q <= level_d;
      trig <= trig_d;
    end
  end

endmodule : t16_capture
`default_nettype wire

// [src/t16_timer.sv]
// 16-bit timer/counter: control registers, counter, compare outputs and capture
// Behaviour
// - Channel A mode bits 7..6 choose pin A action on a non-PWM match.
// - Channel B mode bits 5..4 choose pin B action on a non-PWM match.
// - Mode 00 disconnects, 01 toggles, 10 clears, 11 sets the pin.
// - Compare output reaches the pin only when its direction bit is output.
// - Force A applies the A action with no flag and no counter clear.
// - Force B applies the B action with no flag.
// - Force written with a new mode uses the old mode.
// - Force bits read zero and do nothing while PWM is selected.
// - PWM select 00 off, 01 8-bit, 10 9-bit, 11 10-bit.
// - Filter off captures on first edge; on needs four equal samples.
// - Edge select clear captures on falling edge, set on rising edge.
// - Control B bits 5 and 4 always read zero.
// - Clear-on-match zeroes counter in the clock cycle after an A match.
// - In PWM, clear bit off is up/down, on wraps at top.
// - Clock select picks stop, clock, /8, /64, /256, /1024, pin fall, pin rise.
// - Count pin edges count even when that pin is an output.
// - High byte write goes to latch; low byte write loads all 16 bits.
// - Counter or capture low byte read latches the high byte; their high read returns the latch.
// - One byte latch is shared by counter, compares and capture.
// - Counter resumes from written value at next tick, up or up/down.
// - A counter write suppresses matches for the next timer tick.
// - A match sets its flag the clock cycle after the match.
// - Capture flag pulses in the cycle the capture value changes.
`timescale 1ns/1ps
`default_nettype none
`include "t16_defines.svh"

module t16_timer
  import t16_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic [5:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic COUNT_PIN_INPUT,
  input wire logic CAPTURE_PIN,
  input wire logic PORT_D_BIT_FIVE_DATA,
  input wire logic PORT_D_BIT_FIVE_DIR,
  input wire logic PORT_D_BIT_FOUR_DATA,
  input wire logic PORT_D_BIT_FOUR_DIR,
  output logic PIN_D5_OUT,
  output logic PIN_D5_OE_B,
  output logic PIN_D4_OUT,
  output logic PIN_D4_OE_B,
  output logic COMPARE_OUT_A,
  output logic COMPARE_OUT_B,
  output logic MATCH_A_SET,
  output logic MATCH_B_SET,
  output logic CAPTURE_SET
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  t16_bus_s bus;
  t16_ctrl_a_s ctrl_a_q, ctrl_a_d;
  t16_ctrl_b_s ctrl_b_q, ctrl_b_d;
  logic [15:0] cnt_q, cnt_d;
  logic [15:0] cmp_q [2];
  logic [15:0] cmp_d [2];
  logic [15:0] cap_q, cap_d;
  logic [7:0] latch_q, latch_d;
  logic [7:0] rdata_d;
  logic [9:0] pre_q, pre_d;
  logic pin_prev_q;
  logic block_q, block_d;
  logic down_q, down_d;
  logic [1:0] oc_q, oc_d;
  logic [1:0] flag_q, flag_d;
  logic cap_set_d;
  logic tick;
  logic cap_trig;
  logic pwm_on;
  logic [15:0] top;
  t16_style_e style;
  logic [1:0] match;
  logic [1:0] force_hit;
  logic [1:0] mode [2];
  logic [1:0] pin_dir;

  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  // ----------------------------------------
  // Capture trigger
  // ----------------------------------------
  t16_capture u_capture (
    .clk(CLOCK),
    .rst_b(RST_B),
    .pin(CAPTURE_PIN),
    .filter_en(ctrl_b_q.filter_en),
    .edge_sel(ctrl_b_q.edge_sel),
    .trig(cap_trig)
  );

  // ----------------------------------------
  // Timer tick selection
  // ----------------------------------------
  assign pre_d = pre_q + 10'h001;

  // Prescaler taps and count pin edges
  always_comb begin
    case (ctrl_b_q.clk_sel)
      3'h0: tick = 1'b0;
      3'h1: tick = 1'b1;
      3'h2: tick = &pre_q[2:0];
      3'h3: tick = &pre_q[5:0];
      3'h4: tick = &pre_q[7:0];
      3'h5: tick = &pre_q[9:0];
      3'h6: tick = pin_prev_q & ~COUNT_PIN_INPUT;
      3'h7: tick = ~pin_prev_q & COUNT_PIN_INPUT;
      default: tick = 1'b0;
    endcase
  end

  // Resolution, top and counting style
  always_comb begin
    pwm_on = ctrl_a_q.pwm_res != 2'h0;
    case (ctrl_a_q.pwm_res)
      2'h1: top = `T16_TOP_8;
      2'h2: top = `T16_TOP_9;
      2'h3: top = `T16_TOP_10;
      default: top = 16'hffff;
    endcase
    if (!pwm_on) begin
      style = T16_CNT_NORMAL;
    end else if (ctrl_b_q.clear_on_match_a) begin
      style = T16_CNT_WRAP;
    end else begin
      style = T16_CNT_UPDOWN;
    end
  end

  // ----------------------------------------
  // Compare channels
  // ----------------------------------------
  assign mode[0] = ctrl_a_q.mode_a;
  assign mode[1] = ctrl_a_q.mode_b;
  assign pin_dir = {PORT_D_BIT_FOUR_DIR, PORT_D_BIT_FIVE_DIR};

  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      // Match on equal value, held off for one tick after a counter write
      assign match[ch] = tick && !block_q && ((cnt_q & top) == (cmp_q[ch] & top));
      // Force acts only outside PWM, with the mode already stored
      assign force_hit[ch] = bus.wr && (bus.addr == `T16_OFS_CTRL_A) && !pwm_on
        && bus.wdata[`T16_A_FORCE_B + 1 - ch];

      // Pin action on a real or forced match
      always_comb begin
        oc_d[ch] = oc_q[ch];
        if (!pwm_on && (match[ch] || force_hit[ch])) begin
          case (mode[ch])
            2'h1: oc_d[ch] = ~oc_q[ch];
            2'h2: oc_d[ch] = 1'b0;
            2'h3: oc_d[ch] = 1'b1;
            default: oc_d[ch] = oc_q[ch];
          endcase
        end else if (pwm_on && match[ch] && mode[ch][1]) begin
          // Up match clears, down match sets; inverted when low bit set
          oc_d[ch] = (down_q || style == T16_CNT_WRAP) ? ~mode[ch][0] : mode[ch][0];
          if (style == T16_CNT_WRAP) begin
            oc_d[ch] = mode[ch][0];
          end
        end else if (pwm_on && tick && style == T16_CNT_WRAP && mode[ch][1]
                     && cnt_q == top) begin
          oc_d[ch] = ~mode[ch][0];
        end
        flag_d[ch] = match[ch];
      end
    end
  endgenerate

  // Pin multiplexing behind the port direction bits
  always_comb begin
    PIN_D5_OUT = (pin_dir[0] && mode[0] != 2'h0) ? oc_q[0] : PORT_D_BIT_FIVE_DATA;
    PIN_D4_OUT = (pin_dir[1] && mode[1] != 2'h0) ? oc_q[1] : PORT_D_BIT_FOUR_DATA;
    PIN_D5_OE_B = ~pin_dir[0];
    PIN_D4_OE_B = ~pin_dir[1];
  end

  // ----------------------------------------
  // Registers, counter and shared byte latch
  // ----------------------------------------
  always_comb begin
    ctrl_a_d = ctrl_a_q;
    ctrl_b_d = ctrl_b_q;
    cnt_d = cnt_q;
    cmp_d = cmp_q;
    cap_d = cap_q;
    latch_d = latch_q;
    block_d = block_q;
    down_d = down_q;
    rdata_d = 8'h00;
    cap_set_d = 1'b0;

    // Counting on each timer tick
    if (tick) begin
      block_d = 1'b0;
      case (style)
        T16_CNT_UPDOWN: begin
          if (!down_q && cnt_q >= top) begin
            down_d = 1'b1;
            cnt_d = cnt_q - 16'h0001;
          end else if (down_q && cnt_q == 16'h0000) begin
            down_d = 1'b0;
            cnt_d = 16'h0001;
          end else begin
            cnt_d = down_q ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
          end
        end
        T16_CNT_WRAP: cnt_d = (cnt_q >= top) ? 16'h0000 : cnt_q + 16'h0001;
        default: begin
          if (ctrl_b_q.clear_on_match_a && match[0]) begin
            cnt_d = 16'h0000;
          end else begin
            cnt_d = cnt_q + 16'h0001;
          end
        end
      endcase
    end

    // Capture copies the running count
    if (cap_trig) begin
      cap_d = cnt_q;
      cap_set_d = 1'b1;
    end

    // Register writes
    if (bus.wr) begin
      case (bus.addr)
        `T16_OFS_CTRL_A: begin
          ctrl_a_d = bus.wdata;
          ctrl_a_d.force_a = 1'b0;
          ctrl_a_d.force_b = 1'b0;
        end
        `T16_OFS_CTRL_B: ctrl_b_d = bus.wdata & `T16_CTRL_B_MASK;
        `T16_OFS_CNT_H, `T16_OFS_CMP_A_H, `T16_OFS_CMP_B_H: begin
          latch_d = bus.wdata;
        end
        `T16_OFS_CNT_L: begin
          cnt_d = {latch_q, bus.wdata};
          block_d = 1'b1;
          down_d = 1'b0;
        end
        `T16_OFS_CMP_A_L: cmp_d[0] = {latch_q, bus.wdata};
        `T16_OFS_CMP_B_L: cmp_d[1] = {latch_q, bus.wdata};
        default: ;
      endcase
    end

    // Register reads
    if (bus.rd) begin
      case (bus.addr)
        `T16_OFS_CTRL_A: rdata_d = {ctrl_a_q.mode_a, ctrl_a_q.mode_b, 2'b00, ctrl_a_q.pwm_res};
        `T16_OFS_CTRL_B: rdata_d = ctrl_b_q & `T16_CTRL_B_MASK;
        `T16_OFS_CNT_L: begin
          rdata_d = cnt_q[7:0];
          latch_d = cnt_q[15:8];
        end
        `T16_OFS_CAP_L: begin
          rdata_d = cap_q[7:0];
          latch_d = cap_q[15:8];
        end
        `T16_OFS_CNT_H, `T16_OFS_CAP_H: rdata_d = latch_q;
        `T16_OFS_CMP_A_H: rdata_d = cmp_q[0][15:8];
        `T16_OFS_CMP_A_L: rdata_d = cmp_q[0][7:0];
        `T16_OFS_CMP_B_H: rdata_d = cmp_q[1][15:8];
        `T16_OFS_CMP_B_L: rdata_d = cmp_q[1][7:0];
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // State registers
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_a_q <= `T16_CTRL_A_RST;
      ctrl_b_q <= `T16_CTRL_B_RST;
      cnt_q <= 16'h0000;
      cmp_q[0] <= 16'h0000;
      cmp_q[1] <= 16'h0000;
      cap_q <= 16'h0000;
      latch_q <= 8'h00;
      pre_q <= 10'h000;
      pin_prev_q <= 1'b0;
      block_q <= 1'b0;
      down_q <= 1'b0;
      oc_q <= 2'b00;
      flag_q <= 2'b00;
      CAPTURE_SET <= 1'b0;
      RDATA <= 8'h00;
    end else begin
      ctrl_a_q <= ctrl_a_d;
      ctrl_b_q <= ctrl_b_d;
      cnt_q <= cnt_d;
      cmp_q <= cmp_d;
      cap_q <= cap_d;
      latch_q <= latch_d;
      pre_q <= pre_d;
      pin_prev_q <= COUNT_PIN_INPUT;
      block_q <= block_d;
      down_q <= down_d;
      oc_q <= oc_d;
      flag_q <= flag_d;
      CAPTURE_SET <= cap_set_d;
      RDATA <= rdata_d;
    end
  end

  // Flag pulses and raw compare outputs
  assign MATCH_A_SET = flag_q[0];
  assign MATCH_B_SET = flag_q[1];
  assign COMPARE_OUT_A = oc_q[0];
  assign COMPARE_OUT_B = oc_q[1];

endmodule : t16_timer
`default_nettype wire

// [testbench/t16_cpu_model.sv]
// CPU core model driving the timer register bus
`timescale 1ns/1ps
`default_nettype none

module t16_cpu_model (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic [5:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd
);
  // Idle bus at time zero
  initial begin
    addr = 6'h00;
    wdata = 8'h00;
    wr = 1'h0;
    rd = 1'h0;
  end

  // Byte write, held until the edge that takes it
  task automatic wr8(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask : wr8

  // Byte read, data taken mid-cycle while it stands after the strobe
  task automatic rd8(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    @(negedge clk);
    d = rdata;
  endtask : rd8

  // Wide access: high byte first on write, low byte first on read
  task automatic wr16(input logic [5:0] lo, input logic [15:0] v);
    wr8(lo + 6'h01, v[15:8]);
    wr8(lo, v[7:0]);
  endtask : wr16

  task automatic rd16(input logic [5:0] lo, output logic [15:0] v);
    rd8(lo, v[7:0]);
    rd8(lo + 6'h01, v[15:8]);
  endtask : rd16
endmodule : t16_cpu_model
`default_nettype wire

// [testbench/t16_timer_monitor.sv]
// Port checker of the 16-bit timer, bound to its top module
`timescale 1ns/1ps
`default_nettype none
`include "t16_defines.svh"

module t16_timer_monitor (
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic [5:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic CAPTURE_PIN,
  input wire logic PORT_D_BIT_FIVE_DATA,
  input wire logic PORT_D_BIT_FIVE_DIR,
  input wire logic PORT_D_BIT_FOUR_DIR,
  input wire logic PIN_D5_OUT,
  input wire logic PIN_D5_OE_B,
  input wire logic PIN_D4_OE_B,
  input wire logic COMPARE_OUT_A,
  input wire logic COMPARE_OUT_B,
  input wire logic MATCH_A_SET,
  input wire logic MATCH_B_SET,
  input wire logic CAPTURE_SET
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_B);

  // ----------------
  // Control shadows
  // ----------------
  logic [7:0] ca_q, ca_d, cb_q, cb_d;
  logic wa, idle, fa, fb;

  // Follow control writes seen on the bus
  always_comb begin
    ca_d = (WR && ADDR == `T16_OFS_CTRL_A) ? WDATA : ca_q;
    cb_d = (WR && ADDR == `T16_OFS_CTRL_B) ? WDATA : cb_q;
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      ca_q <= 8'h00;
      cb_q <= 8'h00;
    end else begin
      ca_q <= ca_d;
      cb_q <= cb_d;
    end
  end

  // Force writes while stopped and outside PWM
  assign wa = WR && ADDR == `T16_OFS_CTRL_A;
  assign idle = ca_q[1:0] == 2'h0 && cb_q[2:0] == 3'h0;
  assign fa = wa && WDATA[3] && idle;
  assign fb = wa && WDATA[2] && idle;

  // ----------------
  // Assertions
  // ----------------
  a_rdata_idle_zero: assert property (
    !$past(RD) |-> RDATA == 8'h00) else $error("read data not zero");
  a_ctrl_a_read: assert property (
    $past(RD) && $past(ADDR) == `T16_OFS_CTRL_A |-> RDATA == {ca_q[7:4], 2'h0, ca_q[1:0]})
    else $error("control A readback wrong");
  a_ctrl_b_read: assert property (
    $past(RD) && $past(ADDR) == `T16_OFS_CTRL_B |-> RDATA == (cb_q & 8'hcf))
    else $error("control B readback wrong");
  a_enable_dir: assert property (
    PIN_D5_OE_B == !PORT_D_BIT_FIVE_DIR && PIN_D4_OE_B == !PORT_D_BIT_FOUR_DIR)
    else $error("pin enable wrong");
  a_pin_a_source: assert property (
    PIN_D5_OUT == ((PORT_D_BIT_FIVE_DIR && ca_q[7:6] != 2'h0) ? COMPARE_OUT_A
    : PORT_D_BIT_FIVE_DATA)) else $error("pin A source wrong");
  a_force_a_old: assert property (
    fa && ca_q[7:6] != 2'h0 |=> COMPARE_OUT_A == (($past(ca_q[7:6]) == 2'h1)
    ? !$past(COMPARE_OUT_A) : $past(ca_q[6]))) else $error("force A action wrong");
  a_force_b_old: assert property (
    fb && ca_q[5:4] != 2'h0 |=> COMPARE_OUT_B == (($past(ca_q[5:4]) == 2'h1)
    ? !$past(COMPARE_OUT_B) : $past(ca_q[4]))) else $error("force B action wrong");
  a_force_pwm_none: assert property (
    wa && WDATA[3:2] != 2'h0 && ca_q[1:0] != 2'h0 && cb_q[2:0] == 3'h0
    |=> $stable(COMPARE_OUT_A) && $stable(COMPARE_OUT_B)) else $error("force acted in PWM");
  a_force_no_flag: assert property (
    fa |=> !MATCH_A_SET [*2]) else $error("force raised a flag");
  a_force_b_noflag: assert property (
    fb |=> !MATCH_B_SET [*2]) else $error("force B raised a flag");
  a_capture_edge: assert property (
    !cb_q[7] && $changed(CAPTURE_PIN) && CAPTURE_PIN == cb_q[6] |-> ##[1:3] CAPTURE_SET)
    else $error("capture missing");
endmodule : t16_timer_monitor

bind t16_timer t16_timer_monitor t16_timer_monitor_inst (.CLOCK(CLOCK), .RST_B(RST_B),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .CAPTURE_PIN(CAPTURE_PIN),
  .PORT_D_BIT_FIVE_DATA(PORT_D_BIT_FIVE_DATA), .PORT_D_BIT_FIVE_DIR(PORT_D_BIT_FIVE_DIR),
  .PORT_D_BIT_FOUR_DIR(PORT_D_BIT_FOUR_DIR), .PIN_D5_OUT(PIN_D5_OUT),
  .PIN_D5_OE_B(PIN_D5_OE_B), .PIN_D4_OE_B(PIN_D4_OE_B), .COMPARE_OUT_A(COMPARE_OUT_A),
  .COMPARE_OUT_B(COMPARE_OUT_B), .MATCH_A_SET(MATCH_A_SET), .MATCH_B_SET(MATCH_B_SET),
  .CAPTURE_SET(CAPTURE_SET));
`default_nettype wire

// [testbench/t16_timer_tb_top.sv]
// Self-checking testbench of the 16-bit timer
`timescale 1ns/1ps
`default_nettype none
`include "t16_defines.svh"

module t16_timer_tb_top;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic cnt_pin = 1'h0;
  logic cap_pin = 1'h1;
  logic a_dat = 1'h0;
  logic a_dir = 1'h1;
  logic b_dir = 1'h1;
  logic b_dat = 1'h0;
  wire logic [5:0] addr;
  wire logic [7:0] wdata, rdata;
  wire logic wr, rd, a_out, a_oe_b, b_out, cap_set, m_a;
  int err_total = 0;
  int n_tests = 0;
  int ma_n = 0;
  logic [15:0] v;
  logic [7:0] b;

  // Clock and match pulse counter
  always #10 clk = ~clk;
  always @(posedge clk) if (m_a) ma_n <= ma_n + 1;

  t16_cpu_model t16_cpu_model_inst (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd));
  t16_timer t16_timer_inst (.CLOCK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .COUNT_PIN_INPUT(cnt_pin), .CAPTURE_PIN(cap_pin),
    .PORT_D_BIT_FIVE_DATA(a_dat), .PORT_D_BIT_FIVE_DIR(a_dir), .PORT_D_BIT_FOUR_DATA(b_dat),
    .PORT_D_BIT_FOUR_DIR(b_dir), .PIN_D5_OUT(a_out), .PIN_D5_OE_B(a_oe_b),
    .PIN_D4_OUT(b_out), .PIN_D4_OE_B(), .COMPARE_OUT_A(), .COMPARE_OUT_B(),
    .MATCH_A_SET(m_a), .MATCH_B_SET(), .CAPTURE_SET(cap_set));

  // ----------------
  // Helpers
  // ----------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk);
      cnt_pin <= 1'h1;
      repeat (4) @(posedge clk);
      cnt_pin <= 1'h0;
      repeat (4) @(posedge clk);
    end
  endtask : pulse

  // Bounded watch for a capture pulse
  task automatic cap_wait(input int n, input logic e, input string nm);
    logic s;
    s = 1'h0;
    repeat (n) begin
      @(negedge clk);
      s = s | cap_set;
    end
    chk(nm, 16'(e), 16'(s));
    if (e && !s) tally_and_finish();
  endtask : cap_wait

  // ----------------
  // Scenarios
  // ----------------
  task automatic sc_regs;
    t16_cpu_model_inst.rd8(`T16_OFS_CTRL_A, b);
    chk("ctrl A reset", 16'h0000, 16'(b));
    t16_cpu_model_inst.rd8(6'h00, b);
    chk("unmapped", 16'h0000, 16'(b));
    t16_cpu_model_inst.wr8(`T16_OFS_CTRL_B, 8'hf0);
    t16_cpu_model_inst.rd8(`T16_OFS_CTRL_B, b);
    chk("ctrl B", 16'h00c0, 16'(b));
    t16_cpu_model_inst.wr8(`T16_OFS_CTRL_A, 8'hff);
    t16_cpu_model_inst.rd8(`T16_OFS_CTRL_A, b);
    chk("ctrl A", 16'h00f3, 16'(b));
    t16_cpu_model_inst.wr8(`T16_OFS_CTRL_B, 8'h00);
  endtask : sc_regs

  task automatic sc_latch;
    t16_cpu_model_inst.wr16(`T16_OFS_CNT_L, 16'h1234);
    t16_cpu_model_inst.rd16(`T16_OFS_CNT_L, v);
    chk("count", 16'h1234, v);
    t16_cpu_model_inst.wr8(`T16_OFS_CNT_H, 8'hab);
    t16_cpu_model_inst.wr8(`T16_OFS_CMP_A_H, 8'h56);
    t16_cpu_model_inst.wr8(`T16_OFS_CNT_L, 8'h78);
    t16_cpu_model_inst.rd16(`T16_OFS_CNT_L, v);
    chk("shared latch write", 16'h5678, v);
    t16_cpu_model_inst.rd8(`T16_OFS_CNT_L, b);
    t16_cpu_model_inst.rd8(`T16_OFS_CAP_L, b);
    t16_cpu_model_inst.rd8(`T16_OFS_CNT_H, b);
    chk("shared latch read", 16'h0000, 16'(b));
  endtask : sc_latch

  // Each entry: control A byte, then expected pin A and pin B
  task automatic sc_force;
    logic [9:0] t [10] = '{10'h300, 10'h322, 10'h222, 10'h220, 10'h120, 10'h122,
      10'h0c0, 10'h0d1, 10'h2c7, 10'h2f7};
    foreach (t[i]) begin
      t16_cpu_model_inst.wr8(`T16_OFS_CTRL_A, t[i][9:2]);
      @(negedge clk);
      chk("pin A", 16'(t[i][1]), 16'(a_out));
      chk("pin B", 16'(t[i][0]), 16'(b_out));
    end
    @(posedge clk);
    a_dir <= 1'h0;
    a_dat <= 1'h1;
    b_dir <= 1'h0;
    @(negedge clk);
    chk("port pin A", 16'h0001, 16'(a_out));
    chk("pin A enable", 16'h0001, 16'(a_oe_b));
    chk("port pin B low", 16'h0000, 16'(b_out));
    @(posedge clk);
    b_dat <= 1'h1;
    @(negedge clk);
    chk("port pin B high", 16'h0001, 16'(b_out));
    t16_cpu_model_inst.wr8(`T16_OFS_CTRL_A, 8'h00);
  endtask : sc_force

  task automatic sc_count;
    int ma0;
    t16_cpu_model_inst.wr16(`T16_OFS_CMP_A_L, 16'h0005);
    t16_cpu_model_inst.wr16(`T16_OFS_CNT_L, 16'h0000);
    t16_cpu_model_inst.wr8(`T16_OFS_CTRL_B, 8'h0f);
    ma0 = ma_n;
    pulse(7);
    t16_cpu_model_inst.rd16(`T16_OFS_CNT_L, v);
    chk("clear on match", 16'h0001, v);
    chk("match flags", 16'h0001, 16'(ma_n - ma0));
    t16_cpu_model_inst.wr16(`T16_OFS_CNT_L, 16'h0005);
    pulse(2);
    t16_cpu_model_inst.rd16(`T16_OFS_CNT_L, v);
    chk("match after write", 16'h0007, v);
    t16_cpu_model_inst.wr8(`T16_OFS_CTRL_B, 8'h06);
    t16_cpu_model_inst.wr16(`T16_OFS_CNT_L, 16'h0000);
    pulse(7);
    t16_cpu_model_inst.rd16(`T16_OFS_CNT_L, v);
    chk("no clear", 16'h0007, v);
  endtask : sc_count

  task automatic sc_presc;
    int dv [6] = '{1, 1, 8, 64, 256, 1024};
    logic [15:0] e;
    for (int k = 0; k < 6; k++) begin
      t16_cpu_model_inst.wr16(`T16_OFS_CNT_L, 16'h0000);
      t16_cpu_model_inst.wr8(`T16_OFS_CTRL_B, 8'(k));
      repeat (2048) @(posedge clk);
      t16_cpu_model_inst.wr8(`T16_OFS_CTRL_B, 8'h00);
      t16_cpu_model_inst.rd16(`T16_OFS_CNT_L, v);
      e = (k == 0) ? 16'h0000 : 16'(2050 / dv[k]);
      n_tests++;
      if ($isunknown(v) || v > e + 16'h0001 || v + 16'h0001 < e) begin
        err_total++;
        $display("Error count at select %0d expected %h seen %h", k, e, v);
      end
    end
  endtask : sc_presc

  // PWM counting styles: up/down turns at top, wrap returns to zero
  task automatic sc_pwm;
    logic [7:0] cb [2] = '{8'h01, 8'h09};
    logic [15:0] ex [2] = '{16'h00fc, 16'h0002};
    t16_cpu_model_inst.wr8(`T16_OFS_CTRL_A, 8'h01);
    for (int k = 0; k < 2; k++) begin
      t16_cpu_model_inst.wr16(`T16_OFS_CNT_L, 16'h00fe);
      t16_cpu_model_inst.wr8(`T16_OFS_CTRL_B, cb[k]);
      repeat (2) @(posedge clk);
      t16_cpu_model_inst.wr8(`T16_OFS_CTRL_B, 8'h00);
      t16_cpu_model_inst.rd16(`T16_OFS_CNT_L, v);
      chk("pwm count", ex[k], v);
    end
    t16_cpu_model_inst.wr8(`T16_OFS_CTRL_A, 8'h00);
  endtask : sc_pwm

  task automatic sc_capture;
    t16_cpu_model_inst.wr16(`T16_OFS_CNT_L, 16'h0abc);
    @(posedge clk);
    cap_pin <= 1'h0;
    cap_wait(4, 1'h1, "capture fall");
    t16_cpu_model_inst.rd16(`T16_OFS_CAP_L, v);
    chk("capture value", 16'h0abc, v);
    @(posedge clk);
    cap_pin <= 1'h1;
    cap_wait(6, 1'h0, "capture rise off");
    t16_cpu_model_inst.wr8(`T16_OFS_CTRL_B, 8'hc0);
    @(posedge clk);
    cap_pin <= 1'h0;
    cap_wait(8, 1'h0, "filtered fall");
    @(posedge clk);
    cap_pin <= 1'h1;
    repeat (2) @(posedge clk);
    cap_pin <= 1'h0;
    cap_wait(8, 1'h0, "glitch");
    @(posedge clk);
    cap_pin <= 1'h1;
    cap_wait(10, 1'h1, "filtered rise");
  endtask : sc_capture

  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'h1;
    sc_regs();
    sc_latch();
    sc_force();
    sc_count();
    sc_presc();
    sc_pwm();
    sc_capture();
    tally_and_finish();
  end
endmodule : t16_timer_tb_top
`default_nettype wire
